// File: design/ctd_pkg.sv
// constants for the instruction timing and decode core
// assumes one system clock and a synchronous active-high reset
package ctd_pkg;
  // register addresses in the special function space
  localparam logic [7:0] REG_STACK   = 8'h81;
  localparam logic [7:0] REG_DP_LOW  = 8'h82;
  localparam logic [7:0] REG_DP_HIGH = 8'h83;
  // reset values
  localparam logic [7:0] DP_LOW_RST  = 8'h00;
  localparam logic [7:0] DP_HIGH_RST = 8'h00;
  localparam logic [7:0] STACK_RST   = 8'h07;
  // field layouts
  localparam int BANK_IDX_W = 3;  // bank register index width
  localparam int PAGE_W     = 11; // page target width
  localparam int SPACE_BIT  = 7;  // direct address msb picks register space
  localparam int PAGE_HI_LSB = 5; // opcode bits carrying page target top
  // opcodes with fixed codes
  localparam logic [7:0] OP_NOP       = 8'h00;
  localparam logic [7:0] OP_SPARE     = 8'ha5;
  localparam logic [7:0] OP_LONG_JUMP = 8'h02;
  localparam logic [7:0] OP_LONG_CALL = 8'h12;
  localparam logic [7:0] OP_RETURN    = 8'h22;
  localparam logic [7:0] OP_INT_RET   = 8'h32;
  localparam logic [7:0] OP_SHORT_JMP = 8'h80;
  localparam logic [7:0] OP_IND_JMP   = 8'h73;
  localparam logic [7:0] OP_J_CARRY   = 8'h40;
  localparam logic [7:0] OP_J_NCARRY  = 8'h50;
  localparam logic [7:0] OP_J_ZERO    = 8'h60;
  localparam logic [7:0] OP_J_NZERO   = 8'h70;
  localparam logic [7:0] OP_J_BITCLR  = 8'h10;
  localparam logic [7:0] OP_J_BIT     = 8'h20;
  localparam logic [7:0] OP_J_NBIT    = 8'h30;
  localparam logic [7:0] OP_CMP_ADIR  = 8'hb5;
  localparam logic [7:0] OP_CMP_AIMM  = 8'hb4;
  localparam logic [7:0] OP_DEC_DIR   = 8'hd5;
  localparam logic [7:0] OP_MOVE_DD   = 8'h85;
  localparam logic [7:0] OP_LOAD_DP   = 8'h90;
  localparam logic [7:0] OP_PUSH      = 8'hc0;
  localparam logic [7:0] OP_POP       = 8'hd0;
  localparam logic [7:0] ONE_BYTE     = 8'h01;
  // instruction classes
  typedef enum logic [3:0] {
    K_PLAIN, K_COND, K_PAGE, K_LONG, K_REL, K_INDJ, K_RET, K_LOAD_DP,
    K_PUSH, K_POP, K_XCHG
  } ctd_kind_t;
  // operand addressing
  typedef enum logic [1:0] {A_NONE, A_BANK, A_PTR, A_DIRECT} ctd_amode_t;
  // sequencer states
  typedef enum logic {ST_IDLE, ST_EXEC} ctd_state_t;
endpackage

// File: design/ctd_core.sv
// instruction length, clock count, branch target and pointer registers
// assumes fetch, condition inputs and register port all on clk
`timescale 1ns/1ps

module ctd_core (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // instruction fetch
  input  wire logic        instr_valid,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  operand1,
  input  wire logic [7:0]  operand2,
  output logic             instr_ready,
  output logic             instr_done,
  // condition and operand values
  input  wire logic        carry_flag,
  input  wire logic        bit_value,
  input  wire logic [7:0]  acc_value,
  input  wire logic [7:0]  mem_value,
  input  wire logic [1:0]  register_bank_select,
  input  wire logic [1:0]  flash_read_timing,
  input  wire logic [15:0] return_addr,
  // register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  // decode results
  output logic [15:0]      pc,
  output logic [1:0]       instr_len,
  output logic [3:0]       instr_clks,
  output logic             branch_taken,
  output logic [7:0]       operand_addr,
  output logic             operand_is_reg,
  output logic             bit_clear,
  output logic [7:0]       nibble_acc,
  output logic [7:0]       nibble_mem,
  output logic [15:0]      data_pointer,
  output logic [7:0]       stack_pointer
);
  ctd_pkg::ctd_state_t state_r;          // sequencer state
  ctd_pkg::ctd_state_t state_nxt;        // next sequencer state
  logic [3:0]          cnt_r;            // clocks left
  logic [1:0]          dec_len;          // decoded byte length
  logic [3:0]          dec_base;         // clocks when not taken
  ctd_pkg::ctd_kind_t  dec_kind;         // decoded class
  ctd_pkg::ctd_amode_t dec_amode;        // operand addressing
  logic                dec_cond;         // condition holds
  logic                dec_call;         // pushes a return address
  logic                dec_take;         // flow changes
  logic [3:0]          dec_clks;         // total clocks
  logic [15:0]         nxt_addr;         // first byte of next instruction
  logic [7:0]          rel_byte;         // displacement byte
  logic [15:0]         target;           // new program counter
  logic                accept;           // instruction taken this cycle
  logic                finish;           // instruction ends this cycle
  ctd_pkg::ctd_kind_t  kind_r;           // latched class
  logic                call_r;           // latched call flag
  logic                jbc_r;            // latched set-jump-clear
  logic [15:0]         pend_pc_r;        // latched new pc
  ctd_pkg::ctd_kind_t  f_kind;           // class at finish
  logic                f_call;
  logic                f_jbc;
  logic                f_take;
  logic [15:0]         f_pc;
  logic [15:0]         dp_imm_r;         // latched pointer immediate
  logic [15:0]         f_dp_imm;
  logic [15:0]         pc_r;
  logic [1:0]          len_r;
  logic [3:0]          clks_r;
  logic                taken_r;
  logic                done_r;
  logic                ready_r;
  logic [7:0]          oaddr_r;
  logic                oreg_r;
  logic                bclr_r;
  logic [7:0]          nacc_r;
  logic [7:0]          nmem_r;
  logic [7:0]          dp_low_r;
  logic [7:0]          dp_high_r;
  logic [7:0]          stack_r;
  logic [7:0]          rdata_r;

  // length, base clocks and class per opcode
  always_comb begin
    dec_len   = 2'd1;
    dec_base  = 4'd1;
    dec_kind  = ctd_pkg::K_PLAIN;
    dec_amode = ctd_pkg::A_NONE;
    dec_call  = 1'b0;
    dec_cond  = 1'b0;
    unique casez (opcode)
      8'b???00001, 8'b???10001: begin // page jump and call
        dec_len  = 2'd2;
        dec_base = 4'd3;
        dec_kind = ctd_pkg::K_PAGE;
        dec_call = opcode[4];
      end
      ctd_pkg::OP_LONG_JUMP, ctd_pkg::OP_LONG_CALL: begin
        dec_len  = 2'd3;
        dec_base = 4'd4;
        dec_kind = ctd_pkg::K_LONG;
        dec_call = opcode[4];
      end
      ctd_pkg::OP_RETURN, ctd_pkg::OP_INT_RET: begin
        dec_base = 4'd5;
        dec_kind = ctd_pkg::K_RET;
      end
      ctd_pkg::OP_SHORT_JMP: begin
        dec_len  = 2'd2;
        dec_base = 4'd3;
        dec_kind = ctd_pkg::K_REL;
      end
      ctd_pkg::OP_IND_JMP: begin
        dec_base = 4'd3;
        dec_kind = ctd_pkg::K_INDJ;
      end
      ctd_pkg::OP_J_CARRY, ctd_pkg::OP_J_NCARRY,
      ctd_pkg::OP_J_ZERO, ctd_pkg::OP_J_NZERO: begin
        dec_len  = 2'd2;
        dec_base = 4'd2;
        dec_kind = ctd_pkg::K_COND;
        dec_cond = (opcode == ctd_pkg::OP_J_CARRY)  ?  carry_flag :
                   (opcode == ctd_pkg::OP_J_NCARRY) ? !carry_flag :
                   (opcode == ctd_pkg::OP_J_ZERO)   ? (acc_value == 8'h00) :
                                                      (acc_value != 8'h00);
      end
      ctd_pkg::OP_J_BITCLR, ctd_pkg::OP_J_BIT, ctd_pkg::OP_J_NBIT: begin
        dec_len  = 2'd3;
        dec_base = 4'd3;
        dec_kind = ctd_pkg::K_COND;
        dec_cond = (opcode == ctd_pkg::OP_J_NBIT) ? !bit_value : bit_value;
      end
      ctd_pkg::OP_CMP_ADIR, ctd_pkg::OP_CMP_AIMM, 8'hb6, 8'hb7,
      8'b10111???: begin // compare and jump
        dec_len   = 2'd3;
        dec_kind  = ctd_pkg::K_COND;
        dec_base  = (opcode == ctd_pkg::OP_CMP_ADIR || opcode[3:1] == 3'b011)
                    ? 4'd4 : 4'd3;
        dec_amode = (opcode == ctd_pkg::OP_CMP_ADIR) ? ctd_pkg::A_DIRECT :
                    (opcode[3]) ? ctd_pkg::A_BANK :
                    (opcode[1]) ? ctd_pkg::A_PTR : ctd_pkg::A_NONE;
        dec_cond  = (opcode == ctd_pkg::OP_CMP_AIMM) ? (acc_value != operand1) :
                    (opcode == ctd_pkg::OP_CMP_ADIR) ? (acc_value != mem_value) :
                                                       (mem_value != operand1);
      end
      ctd_pkg::OP_DEC_DIR, 8'b11011???: begin // decrement and jump
        dec_len   = opcode[3] ? 2'd2 : 2'd3;
        dec_base  = opcode[3] ? 4'd2 : 4'd3;
        dec_kind  = ctd_pkg::K_COND;
        dec_amode = opcode[3] ? ctd_pkg::A_BANK : ctd_pkg::A_DIRECT;
        dec_cond  = (mem_value != ctd_pkg::ONE_BYTE);
      end
      8'he0, 8'hf0, 8'he2, 8'he3, 8'hf2, 8'hf3, 8'h93, 8'h83: begin
        dec_base  = 4'd3;
        dec_amode = opcode[1] ? ctd_pkg::A_PTR : ctd_pkg::A_NONE;
      end
      ctd_pkg::OP_MOVE_DD: begin
        dec_len   = 2'd3;
        dec_base  = 4'd3;
        dec_amode = ctd_pkg::A_DIRECT;
      end
      ctd_pkg::OP_LOAD_DP: begin
        dec_len  = 2'd3;
        dec_base = 4'd3;
        dec_kind = ctd_pkg::K_LOAD_DP;
      end
      8'he6, 8'he7, 8'hf6, 8'hf7: begin
        dec_base  = 4'd2;
        dec_amode = ctd_pkg::A_PTR;
      end
      ctd_pkg::OP_PUSH, ctd_pkg::OP_POP: begin
        dec_len   = 2'd2;
        dec_base  = 4'd2;
        dec_kind  = opcode[4] ? ctd_pkg::K_POP : ctd_pkg::K_PUSH;
        dec_amode = ctd_pkg::A_DIRECT;
      end
      8'hd6, 8'hd7: begin
        dec_base  = 4'd2;
        dec_kind  = ctd_pkg::K_XCHG;
        dec_amode = ctd_pkg::A_PTR;
      end
      8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92: begin
        dec_len  = 2'd2;
        dec_base = 4'd2;
      end
      // accumulator, carry-only, no-op and spare: one byte, one clock; direct-byte and bank moves below take more
      default: begin
        dec_len  = 2'd1;
        dec_base = 4'd1;
        // low nibble 8-f names a bank register, low nibble 5 a direct byte except on the spare opcode
        if (opcode[3]) begin
          dec_amode = ctd_pkg::A_BANK;
          // immediate or direct moves into and out of a bank register: two bytes
          if (opcode[7:4] == 4'h7 || opcode[7:4] == 4'h8 || opcode[7:4] == 4'ha) begin
            dec_len  = 2'd2;
            dec_base = 4'd2;
          end
        end else if (opcode[3:0] == 4'h5 && opcode != ctd_pkg::OP_SPARE) begin
          dec_amode = ctd_pkg::A_DIRECT;
          // immediate to direct byte carries three bytes, the others two
          dec_len   = (opcode[7:4] == 4'h7) ? 2'd3 : 2'd2;
          dec_base  = (opcode[7:4] == 4'h7) ? 4'd3 : 4'd2;
        end
      end
    endcase
  end

  // flow change, target and total clocks
  always_comb begin
    nxt_addr = pc_r + {14'h0000, dec_len};
    rel_byte = (dec_len == 2'd2) ? operand1 : operand2;
    dec_take = (dec_kind == ctd_pkg::K_COND) ? dec_cond :
               (dec_kind == ctd_pkg::K_PAGE || dec_kind == ctd_pkg::K_LONG ||
                dec_kind == ctd_pkg::K_REL || dec_kind == ctd_pkg::K_INDJ ||
                dec_kind == ctd_pkg::K_RET);
    unique case (dec_kind)
      ctd_pkg::K_PAGE: target = {nxt_addr[15:ctd_pkg::PAGE_W],
                                 opcode[7:ctd_pkg::PAGE_HI_LSB], operand1};
      ctd_pkg::K_LONG: target = {operand1, operand2};
      ctd_pkg::K_INDJ: target = {dp_high_r, dp_low_r} + {8'h00, acc_value};
      ctd_pkg::K_RET:  target = return_addr;
      // an untaken conditional falls through to the next instruction
      ctd_pkg::K_COND, ctd_pkg::K_REL:
        target = (dec_kind == ctd_pkg::K_REL || dec_cond)
                 ? nxt_addr + {{8{rel_byte[7]}}, rel_byte} : nxt_addr;
      default:         target = nxt_addr;
    endcase
    // taken conditional costs one more; odd target of a taken branch waits on flash timing
    dec_clks = dec_base
             + {3'b000, (dec_kind == ctd_pkg::K_COND) && dec_cond}
             + ((dec_take && target[0]) ? {2'b00, flash_read_timing} : 4'd0);
  end

  // handshake and finish detect
  assign accept = ce && instr_valid && (state_r == ctd_pkg::ST_IDLE);
  assign finish = (accept && dec_clks == 4'd1) ||
                  (ce && state_r == ctd_pkg::ST_EXEC && cnt_r == 4'd0);
  // single clock instructions finish on the accept cycle itself
  assign f_kind   = accept ? dec_kind : kind_r;
  assign f_call   = accept ? dec_call : call_r;
  assign f_jbc    = accept ? (opcode == ctd_pkg::OP_J_BITCLR) : jbc_r;
  assign f_take   = accept ? dec_take : taken_r;
  assign f_pc     = accept ? target : pend_pc_r;
  assign f_dp_imm = accept ? {operand1, operand2} : dp_imm_r;

  // next state
  always_comb begin
    state_nxt = state_r;
    if (accept && dec_clks != 4'd1) begin
      state_nxt = ctd_pkg::ST_EXEC;
    end else if (finish) begin
      state_nxt = ctd_pkg::ST_IDLE;
    end
  end

  // sequencer and clock counter
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ctd_pkg::ST_IDLE;
      cnt_r   <= 4'd0;
      ready_r <= 1'b1;
      done_r  <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      ready_r <= (state_nxt == ctd_pkg::ST_IDLE);
      done_r  <= finish;
      if (accept) begin
        cnt_r <= dec_clks - 4'd2;
      end else if (state_r == ctd_pkg::ST_EXEC && cnt_r != 4'd0) begin
        cnt_r <= cnt_r - 4'd1;
      end
    end
  end

  // per-instruction results latched at accept
  always_ff @(posedge clk) begin
    if (srst) begin
      kind_r    <= ctd_pkg::K_PLAIN;
      call_r    <= 1'b0;
      jbc_r     <= 1'b0;
      pend_pc_r <= 16'h0000;
      dp_imm_r  <= 16'h0000;
      len_r     <= 2'd0;
      clks_r    <= 4'd0;
      taken_r   <= 1'b0;
      oaddr_r   <= 8'h00;
      oreg_r    <= 1'b0;
      nacc_r    <= 8'h00;
      nmem_r    <= 8'h00;
    end else if (accept) begin
      kind_r    <= dec_kind;
      call_r    <= dec_call;
      jbc_r     <= (opcode == ctd_pkg::OP_J_BITCLR);
      pend_pc_r <= target;
      dp_imm_r  <= {operand1, operand2};
      len_r     <= dec_len;
      clks_r    <= dec_clks;
      taken_r   <= dec_take;
      unique case (dec_amode)
        ctd_pkg::A_BANK: oaddr_r <= {3'b000, register_bank_select,
                                     opcode[ctd_pkg::BANK_IDX_W-1:0]};
        ctd_pkg::A_PTR:  oaddr_r <= {3'b000, register_bank_select,
                                     2'b00, opcode[0]};
        ctd_pkg::A_DIRECT: oaddr_r <= operand1;
        ctd_pkg::A_NONE:   oaddr_r <= 8'h00;
      endcase
      oreg_r <= (dec_amode == ctd_pkg::A_DIRECT) && operand1[ctd_pkg::SPACE_BIT];
      if (dec_kind == ctd_pkg::K_XCHG) begin
        nacc_r <= {acc_value[7:4], mem_value[3:0]};
        nmem_r <= {mem_value[7:4], acc_value[3:0]};
      end
    end
  end

  // program counter and set-jump-clear pulse at finish
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_r   <= 16'h0000;
      bclr_r <= 1'b0;
    end else if (ce) begin
      bclr_r <= finish && f_jbc && f_take;
      if (finish) begin
        pc_r <= f_pc;
      end
    end
  end

  // stack pointer: push and call pre-increment, pop and return decrement
  always_ff @(posedge clk) begin
    if (srst) begin
      stack_r <= ctd_pkg::STACK_RST;
    end else if (ce) begin
      if (reg_wr && reg_addr == ctd_pkg::REG_STACK) begin
        stack_r <= reg_wdata;
      end else if (finish && f_kind == ctd_pkg::K_PUSH) begin
        stack_r <= stack_r + 8'h01;
      end else if (finish && f_call) begin
        stack_r <= stack_r + 8'h02;
      end else if (finish && f_kind == ctd_pkg::K_POP) begin
        stack_r <= stack_r - 8'h01;
      end else if (finish && f_kind == ctd_pkg::K_RET) begin
        stack_r <= stack_r - 8'h02;
      end
    end
  end

  // data pointer bytes: register writes win over immediate load
  always_ff @(posedge clk) begin
    if (srst) begin
      dp_low_r  <= ctd_pkg::DP_LOW_RST;
      dp_high_r <= ctd_pkg::DP_HIGH_RST;
    end else if (ce) begin
      if (finish && f_kind == ctd_pkg::K_LOAD_DP) begin
        {dp_high_r, dp_low_r} <= f_dp_imm;
      end
      if (reg_wr && reg_addr == ctd_pkg::REG_DP_LOW) begin
        dp_low_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == ctd_pkg::REG_DP_HIGH) begin
        dp_high_r <= reg_wdata;
      end
    end
  end

  // register read, unmapped reads zero
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r <= 8'h00;
    end else if (ce && reg_rd) begin
      unique case (reg_addr)
        ctd_pkg::REG_DP_LOW:  rdata_r <= dp_low_r;
        ctd_pkg::REG_DP_HIGH: rdata_r <= dp_high_r;
        ctd_pkg::REG_STACK:   rdata_r <= stack_r;
        default:              rdata_r <= 8'h00;
      endcase
    end
  end

  // outputs straight from flops
  assign instr_ready    = ready_r;
  assign instr_done     = done_r;
  assign pc             = pc_r;
  assign instr_len      = len_r;
  assign instr_clks     = clks_r;
  assign branch_taken   = taken_r;
  assign operand_addr   = oaddr_r;
  assign operand_is_reg = oreg_r;
  assign bit_clear      = bclr_r;
  assign nibble_acc     = nacc_r;
  assign nibble_mem     = nmem_r;
  assign data_pointer   = {dp_high_r, dp_low_r};
  assign stack_pointer  = stack_r;
  assign reg_rdata      = rdata_r;

  // checks
  logic [3:0] elapsed_r; // ce cycles since accept
  always_ff @(posedge clk) begin
    if (srst) begin
      elapsed_r <= 4'd0;
    end else if (accept) begin
      elapsed_r <= 4'd1;
    end else if (ce && state_r == ctd_pkg::ST_EXEC) begin
      elapsed_r <= elapsed_r + 4'd1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic       op1_msb;
  logic [3:0] acc_hi;
  logic [3:0] mem_lo;
  assign op1_msb = operand1[7];
  assign acc_hi  = acc_value[7:4];
  assign mem_lo  = mem_value[3:0];

  property p_clock_count;
    done_r |-> elapsed_r == clks_r;
  endproperty
  a_clock_count: assert property (p_clock_count) else $error("clock count wrong");
  property p_carry_untaken;
    accept && opcode == ctd_pkg::OP_J_CARRY && !carry_flag |=> clks_r == 4'd2 && !taken_r;
  endproperty
  a_carry_untaken: assert property (p_carry_untaken) else $error("untaken jump");
  property p_external_move;
    accept && opcode == 8'he0 |=> len_r == 2'd1 && clks_r == 4'd3 ##2 done_r;
  endproperty
  a_external_move: assert property (p_external_move) else $error("external move");
  property p_spare_op;
    accept && opcode == ctd_pkg::OP_SPARE |=> done_r && len_r == 2'd1 && clks_r == 4'd1;
  endproperty
  a_spare_op: assert property (p_spare_op) else $error("spare opcode");
  property p_pc_advance;
    done_r && !taken_r |-> pc_r == $past(pc_r) + {14'h0000, len_r};
  endproperty
  a_pc_advance: assert property (p_pc_advance) else $error("pc advance");
  property p_bit_clear;
    accept && opcode == ctd_pkg::OP_J_BITCLR && bit_value && flash_read_timing == 2'd0
      |=> ##3 bit_clear;
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("bit not cleared");
  property p_push_inc;
    done_r && kind_r == ctd_pkg::K_PUSH && !$past(reg_wr) |-> stack_r == $past(stack_r) + 8'h01;
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("push increment");
  property p_space;
    accept && opcode == ctd_pkg::OP_MOVE_DD |=> operand_is_reg == $past(op1_msb);
  endproperty
  a_space: assert property (p_space) else $error("direct space");
  property p_nibble;
    accept && opcode == 8'hd6 |=> nacc_r == {$past(acc_hi), $past(mem_lo)};
  endproperty
  a_nibble: assert property (p_nibble) else $error("nibble exchange");
  property p_dp_reset;
    $fell(srst) |-> dp_low_r == 8'h00 && stack_r == 8'h07;
  endproperty
  a_dp_reset: assert property (p_dp_reset) else $error("reset values");
endmodule

// File: verification/ctd_data_mem.sv
// data memory model feeding operand bytes to the core
// assumes the bench picks which location is being read
`timescale 1ns/1ps
module ctd_data_mem (
  // read side
  input  wire logic [7:0] rd_addr,
  output logic [7:0]      rd_data
);
  // contents: each location holds its own address
  logic [7:0] mem [256];
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0];
  // combinational read, no hold of an older value
  assign rd_data = mem[rd_addr];
endmodule

// File: verification/cpu_instruction_timing_decode_bench.sv
// bench for the instruction timing and decode core
// assumes ctd_data_mem supplies the operand byte
`timescale 1ns/1ps
module cpu_instruction_timing_decode_bench;
  // stimulus and observed signals
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, instr_valid = 1'b0, carry_flag = 1'b0;
  logic bit_value = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, bc;
  logic [7:0] opcode = 8'h00, operand1 = 8'h00, operand2 = 8'h00, acc_value = 8'h3c;
  logic [7:0] mem_addr = 8'h5a, reg_addr = 8'h00, reg_wdata = 8'h00, mem_value, reg_rdata;
  logic [7:0] operand_addr, nibble_acc, nibble_mem, stack_pointer;
  logic instr_ready, instr_done, branch_taken, operand_is_reg, bit_clear;
  logic [1:0] register_bank_select = 2'h0, flash_read_timing = 2'h0, instr_len;
  logic [3:0] instr_clks;
  logic [15:0] return_addr = 16'h1300, pc, data_pointer, xp = 16'h0000;
  int fail_count = 0, tests_run = 0, cyc = 0;
  // design under test and partner
  ctd_core i_ctd_core (.clk, .srst, .ce, .instr_valid, .opcode, .operand1, .operand2,
    .instr_ready, .instr_done, .carry_flag, .bit_value, .acc_value, .mem_value,
    .register_bank_select, .flash_read_timing, .return_addr, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .pc, .instr_len, .instr_clks, .branch_taken, .operand_addr,
    .operand_is_reg, .bit_clear, .nibble_acc, .nibble_mem, .data_pointer, .stack_pointer);
  ctd_data_mem i_ctd_data_mem (.rd_addr(mem_addr), .rd_data(mem_value));
  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      results();
    end
  end
  // value comparison
  task automatic cmp(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // verdict and end of run
  task automatic results();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // register port cycles
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp("reg_rdata", e, reg_rdata);
  endtask
  // one instruction: clocks counted from accept edge to done
  task automatic ex(input logic [7:0] op, a, b, input logic [1:0] l, input logic [3:0] c,
                    input logic t, input logic [15:0] np);
    int n;
    n = 1;
    bc = 1'b0;
    @(posedge clk);
    instr_valid <= 1'b1;
    opcode <= op;
    operand1 <= a;
    operand2 <= b;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    cmp("instr_ready", c == 4'h1, instr_ready);
    while (instr_done !== 1'b1 && n < 16) begin
      bc |= bit_clear;
      @(posedge clk);
      #1 n++;
    end
    bc |= bit_clear;
    cmp("clocks", c, n[15:0]);
    cmp("instr_ready", 1'b1, instr_ready);
    cmp("instr_clks", c, instr_clks);
    cmp("instr_len", l, instr_len);
    cmp("branch_taken", t, branch_taken);
    cmp("pc", np, pc);
    xp = np;
  endtask
  // grouped opcodes sharing one length and clock count
  task automatic grp(input logic [7:0] q[$], input logic [1:0] l, input logic [3:0] c);
    foreach (q[i]) ex(q[i], 8'h30, 8'h40, l, c, 1'b0, xp + l);
  endtask
  // scenarios
  task automatic t_regs();
    cmp("stack_pointer", 8'h07, stack_pointer);
    rd(8'h82, 8'h00);
    wr(8'h82, 8'h5c);
    rd(8'h82, 8'h5c);
    wr(8'h83, 8'h12);
    #1 cmp("data_pointer", 16'h125c, data_pointer);
    // a write while the enable is low must leave the pointer frozen
    ce <= 1'b0;
    wr(8'h82, 8'hff);
    ce <= 1'b1;
    #1 cmp("data_pointer", 16'h125c, data_pointer);
    rd(8'h84, 8'h00);
  endtask
  task automatic t_table();
    grp('{8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3}, 2'h1, 4'h3);
    grp('{8'h93, 8'h83}, 2'h1, 4'h3);
    grp('{8'h85, 8'h90}, 2'h3, 4'h3);
    cmp("data_pointer", 16'h3040, data_pointer);
    grp('{8'he6, 8'hf7, 8'hd6}, 2'h1, 4'h2);
    cmp("nibble_acc", 8'h3a, nibble_acc);
    cmp("nibble_mem", 8'h5c, nibble_mem);
    grp('{8'hc0, 8'hc0, 8'hd0}, 2'h2, 4'h2);
    cmp("stack_pointer", 8'h08, stack_pointer);
    grp('{8'he4, 8'hf4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4}, 2'h1, 4'h1);
    grp('{8'hc3, 8'hd3, 8'hb3}, 2'h1, 4'h1);
    grp('{8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92}, 2'h2, 4'h2);
    grp('{8'ha5, 8'h00}, 2'h1, 4'h1);
  endtask
  task automatic t_branch();
    ex(8'h02, 8'h12, 8'h34, 2'h3, 4'h4, 1'b1, 16'h1234);
    ex(8'h40, 8'h10, 8'h00, 2'h2, 4'h2, 1'b0, 16'h1236);
    carry_flag <= 1'b1;
    ex(8'h40, 8'h10, 8'h00, 2'h2, 4'h3, 1'b1, 16'h1248);
    ex(8'h50, 8'h10, 8'h00, 2'h2, 4'h2, 1'b0, 16'h124a);
    acc_value <= 8'h00;
    ex(8'h60, 8'hf0, 8'h00, 2'h2, 4'h3, 1'b1, 16'h123c);
    ex(8'h70, 8'hf0, 8'h00, 2'h2, 4'h2, 1'b0, 16'h123e);
    bit_value <= 1'b1;
    ex(8'h10, 8'h20, 8'h02, 2'h3, 4'h4, 1'b1, 16'h1243);
    cmp("bit_clear", 1'b1, bc);
    bit_value <= 1'b0;
    ex(8'h20, 8'h20, 8'h02, 2'h3, 4'h3, 1'b0, 16'h1246);
    ex(8'h30, 8'h20, 8'h04, 2'h3, 4'h4, 1'b1, 16'h124d);
    cmp("bit_clear", 1'b0, bc);
    acc_value <= 8'h05;
    ex(8'hb4, 8'h05, 8'h10, 2'h3, 4'h3, 1'b0, 16'h1250);
    ex(8'hb5, 8'h40, 8'h10, 2'h3, 4'h5, 1'b1, 16'h1263);
    mem_addr <= 8'h01;
    ex(8'hd8, 8'h02, 8'h00, 2'h2, 4'h2, 1'b0, 16'h1265);
    mem_addr <= 8'h03;
    ex(8'hd5, 8'h30, 8'h02, 2'h3, 4'h4, 1'b1, 16'h126a);
    ex(8'h61, 8'h56, 8'h00, 2'h2, 4'h3, 1'b1, 16'h1356);
    ex(8'h12, 8'h20, 8'h00, 2'h3, 4'h4, 1'b1, 16'h2000);
    ex(8'h11, 8'h40, 8'h00, 2'h2, 4'h3, 1'b1, 16'h2040);
    cmp("stack_pointer", 8'h0c, stack_pointer);
    ex(8'h22, 8'h00, 8'h00, 2'h1, 4'h5, 1'b1, 16'h1300);
    ex(8'h32, 8'h00, 8'h00, 2'h1, 4'h5, 1'b1, 16'h1300);
    cmp("stack_pointer", 8'h08, stack_pointer);
    ex(8'h73, 8'h00, 8'h00, 2'h1, 4'h3, 1'b1, 16'h3045);
    flash_read_timing <= 2'h2;
    ex(8'h80, 8'h00, 8'h00, 2'h2, 4'h5, 1'b1, 16'h3047);
    flash_read_timing <= 2'h0;
  endtask
  task automatic t_addr();
    for (int r = 0; r < 4; r++) begin
      register_bank_select <= r[1:0];
      ex(8'he9, 8'h00, 8'h00, 2'h1, 4'h1, 1'b0, xp + 16'h1);
      cmp("operand_addr", {3'h0, r[1:0], 3'h1}, operand_addr);
    end
    ex(8'he5, 8'h90, 8'h00, 2'h2, 4'h2, 1'b0, xp + 16'h2);
    cmp("operand_is_reg", 1'b1, operand_is_reg);
    ex(8'he5, 8'h7f, 8'h00, 2'h2, 4'h2, 1'b0, xp + 16'h2);
    cmp("operand_is_reg", 1'b0, operand_is_reg);
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_table();
    t_branch();
    t_addr();
    results();
  end
endmodule
